// ==== src/fdm_pkg.sv ====
`default_nettype none
package fdm_pkg;

  // Parameter indices of the category allow flags
  localparam logic [15:0] IDX_WHEEL_ALLOW = 16'hfa0b;
  localparam logic [15:0] IDX_SPEED_ALLOW = 16'hfa0c;
  localparam logic [15:0] IDX_PRIMARY_ALLOW = 16'hfa0d;
  localparam logic [15:0] IDX_SECONDARY_ALLOW = 16'hfa0e;

  // Allow flag coding
  localparam logic [7:0] ALLOW_FALSE = 8'h00;
  localparam logic [7:0] ALLOW_TRUE = 8'hff;
  localparam logic [7:0] ALLOW_RESET = 8'h00;

  // Fault categories, bit positions in the category vectors
  localparam int unsigned N_CAT = 4;
  localparam int unsigned CAT_PRIMARY = 0;
  localparam int unsigned CAT_SECONDARY = 1;
  localparam int unsigned CAT_SPEED = 2;
  localparam int unsigned CAT_WHEEL = 3;

  // Diagnostic check sources: CAN, analogue, bridge, peripheral, software
  localparam int unsigned N_DIAG = 5;

  // Critical fault log
  localparam int unsigned ERR_DEPTH = 8;
  localparam int unsigned ERR_AW = 3;
  localparam int unsigned CODE_W = 4;
  localparam logic [3:0] CODE_CAT_BASE = 4'h1;
  localparam logic [3:0] CODE_DIAG_BASE = 4'h8;
  localparam logic [3:0] ERR_CNT_FULL = 4'h8;

  // Operation states, Gray steps boot-oper-reduced-fail
  typedef enum logic [2:0] {
    ST_BOOT = 3'h0,
    ST_OPER = 3'h1,
    ST_RED = 3'h3,
    ST_FAIL = 3'h2,
    ST_CAL = 3'h6
  } fdm_state_type;

  // Status broadcast timing
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned STATUS_PERIOD_MS = 10;
  localparam int unsigned STATUS_PERIOD_CYC = (CLK_FREQ_HZ / 1000) * STATUS_PERIOD_MS;
  localparam int unsigned STATUS_CNT_W = 24;

endpackage : fdm_pkg
`default_nettype wire

// ==== src/fdm_allow_reg.sv ====
`timescale 1ns/1ps
`default_nettype none
module fdm_allow_reg (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Write port
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  // Flag state
  output logic [7:0] val_o,
  output logic true_o
);

  logic [7:0] val_ff;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      val_ff <= fdm_pkg::ALLOW_RESET;
    end else if (wr_i) begin
      val_ff <= wdata_i;
    end
  end

  assign val_o = val_ff;
  assign true_o = (val_ff == fdm_pkg::ALLOW_TRUE);

endmodule : fdm_allow_reg
`default_nettype wire

// ==== src/fdm_err_buf.sv ====
`timescale 1ns/1ps
`default_nettype none
module fdm_err_buf (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Log port
  input wire logic wr_i,
  input wire logic [3:0] code_i,
  // Read port
  input wire logic [2:0] rd_idx_i,
  output logic [3:0] rd_code_o,
  output logic [3:0] count_o
);

  logic [3:0] mem [fdm_pkg::ERR_DEPTH];
  logic [3:0] count_ff;
  logic [3:0] rd_code_ff;

  // Saturates when full so the first faults survive
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_ff <= 4'h0;
    end else if (wr_i && (count_ff != fdm_pkg::ERR_CNT_FULL)) begin
      count_ff <= count_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_i && (count_ff != fdm_pkg::ERR_CNT_FULL)) begin
      mem[count_ff[2:0]] <= code_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_code_ff <= 4'h0;
    end else if ({1'b0, rd_idx_i} < count_ff) begin
      rd_code_ff <= mem[rd_idx_i];
    end else begin
      rd_code_ff <= 4'h0;
    end
  end

  assign rd_code_o = rd_code_ff;
  assign count_o = count_ff;

endmodule : fdm_err_buf
`default_nettype wire

// ==== src/fdm_manager.sv ====
// Notes on behaviour
// RULE1 - Four fault categories, each separately degradable
// RULE2 - Flag 0 false, 255 true; false means fail-safe
// RULE3 - Primary fault: reduced, primary disabled for good
// RULE4 - Secondary fault: reduced, secondary disabled for good
// RULE5 - Device flags cover analogue and CAN variants
// RULE6 - Speed fault: bypass speed sensitivity, assume maximum
// RULE7 - Speed fault: bypass speed ramp selection too
// RULE8 - Speed fault: transitions ignore speed condition
// RULE9 - Wheel fault: bypass soft-stop, actuator sensitivity
// RULE10 - Wheel fault: refuse all closed-loop control
// RULE11 - Signal faults only bypass their consuming functions
// RULE12 - Every fault gives reduced or fail-safe state; a flag-true fault in calibration keeps calibration
// RULE13 - Fail-safe switches the valve bridge off
// RULE14 - Critical faults logged in readable buffer
// RULE15 - Fail-safe answers reads, rejects parameter writes
// RULE16 - Writes only in operational, reduced, calibration
// RULE17 - Leaving fail-safe needs a power cycle
// RULE18 - Diagnostic faults from five check sources
// RULE19 - Safety critical faults force fail-safe
// RULE20 - Operation state broadcast periodically
// RULE21 - Fail-safe latched until reset
// RULE22 - Reduced restrictions of categories accumulate
`timescale 1ns/1ps
`default_nettype none
module fdm_manager #(
  parameter int unsigned STATUS_PERIOD = fdm_pkg::STATUS_PERIOD_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Calibration strap, caught after reset release
  input wire logic cal_strap_i,
  // Fault events, one-cycle pulses
  input wire logic [3:0] cat_fault_i,
  input wire logic [4:0] diag_fault_i,
  // Function requests, bit 0 analogue, bit 1 CAN
  input wire logic [1:0] primary_en_req_i,
  input wire logic [1:0] secondary_en_req_i,
  input wire logic closed_loop_req_i,
  // Parameter access
  input wire logic par_wr_i,
  input wire logic par_rd_i,
  input wire logic [15:0] par_idx_i,
  input wire logic [7:0] par_wdata_i,
  output logic par_ack_o,
  output logic par_rej_o,
  output logic [7:0] par_rdata_o,
  // Critical fault log
  input wire logic [2:0] err_rd_idx_i,
  output logic [3:0] err_rd_code_o,
  output logic [3:0] err_count_o,
  // State and status broadcast
  output logic [2:0] op_state_o,
  output logic status_tx_o,
  output logic [2:0] status_state_o,
  output logic critical_o,
  output logic valve_bridge_en_o,
  // Steering function controls
  output logic [1:0] primary_dev_en_o,
  output logic [1:0] secondary_dev_en_o,
  output logic speed_sens_bypass_o,
  output logic speed_ramp_bypass_o,
  output logic trans_speed_ignore_o,
  output logic assume_max_speed_o,
  output logic soft_stop_bypass_o,
  output logic act_sens_bypass_o,
  output logic closed_loop_en_o
);

  fdm_pkg::fdm_state_type state_ff;
  fdm_pkg::fdm_state_type nxt_state;

  logic [3:0] allow_true;
  logic [7:0] allow_val [fdm_pkg::N_CAT];
  logic [3:0] idx_hit;
  logic [3:0] deg_ff;
  logic [3:0] deg_set;
  logic [3:0] crit_cat;
  logic crit_any;
  logic [3:0] crit_code;
  logic run_state;
  logic wr_state_ok;
  logic wr_legal;
  logic wr_accept;

  logic par_ack_ff;
  logic par_rej_ff;
  logic [7:0] par_rdata_ff;
  logic [7:0] nxt_rdata;

  logic [1:0] primary_en_ff;
  logic [1:0] secondary_en_ff;
  logic closed_loop_ff;

  logic [fdm_pkg::STATUS_CNT_W-1:0] status_cnt_ff;
  logic status_tx_ff;
  logic [2:0] status_state_ff;

  function automatic logic [15:0] cat_index(input int unsigned cat);
    case (cat)
      fdm_pkg::CAT_PRIMARY: cat_index = fdm_pkg::IDX_PRIMARY_ALLOW;
      fdm_pkg::CAT_SECONDARY: cat_index = fdm_pkg::IDX_SECONDARY_ALLOW;
      fdm_pkg::CAT_SPEED: cat_index = fdm_pkg::IDX_SPEED_ALLOW;
      default: cat_index = fdm_pkg::IDX_WHEEL_ALLOW;
    endcase
  endfunction : cat_index

  // Parameter writes gated by state
  // RULE16 writable states only
  assign run_state = (state_ff == fdm_pkg::ST_OPER) || (state_ff == fdm_pkg::ST_RED)
                     || (state_ff == fdm_pkg::ST_CAL);
  assign wr_state_ok = run_state;
  // RULE2 only codes 0 and 255
  assign wr_legal = (par_wdata_i == fdm_pkg::ALLOW_FALSE) || (par_wdata_i == fdm_pkg::ALLOW_TRUE);
  assign wr_accept = par_wr_i && wr_state_ok && wr_legal && (|idx_hit);

  // RULE1 one flag per category
  genvar gi;
  generate
    for (gi = 0; gi < fdm_pkg::N_CAT; gi++) begin : g_allow
      assign idx_hit[gi] = (par_idx_i == cat_index(gi));
      fdm_allow_reg u_allow (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .wr_i(wr_accept && idx_hit[gi]),
        .wdata_i(par_wdata_i),
        .val_o(allow_val[gi]),
        .true_o(allow_true[gi])
      );
    end
  endgenerate

  // Fault classification
  // RULE2 false flag is critical
  assign crit_cat = cat_fault_i & ~allow_true;
  assign deg_set = cat_fault_i & allow_true;
  // RULE18 five diagnostic sources
  // RULE19 diagnostic faults are critical
  assign crit_any = (|crit_cat) || (|diag_fault_i);

  // Lowest source wins when several arrive together
  always_comb begin
    crit_code = 4'h0;
    for (int i = fdm_pkg::N_DIAG - 1; i >= 0; i--) begin
      if (diag_fault_i[i]) begin
        crit_code = fdm_pkg::CODE_DIAG_BASE + 4'(i);
      end
    end
    for (int i = fdm_pkg::N_CAT - 1; i >= 0; i--) begin
      if (crit_cat[i]) begin
        crit_code = fdm_pkg::CODE_CAT_BASE + 4'(i);
      end
    end
  end

  // State machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      fdm_pkg::ST_BOOT: begin
        if (crit_any) begin
          nxt_state = fdm_pkg::ST_FAIL;
        end else if (cal_strap_i) begin
          nxt_state = fdm_pkg::ST_CAL;
        end else begin
          nxt_state = fdm_pkg::ST_OPER;
        end
      end
      fdm_pkg::ST_OPER: begin
        // RULE12 fault to reduced or fail
        if (crit_any) begin
          nxt_state = fdm_pkg::ST_FAIL;
        end else if (|deg_set) begin
          nxt_state = fdm_pkg::ST_RED;
        end
      end
      fdm_pkg::ST_RED, fdm_pkg::ST_CAL: begin
        if (crit_any) begin
          nxt_state = fdm_pkg::ST_FAIL;
        end
      end
      fdm_pkg::ST_FAIL: begin
        // RULE21 no exit but reset
        nxt_state = fdm_pkg::ST_FAIL;
      end
      default: begin
        nxt_state = fdm_pkg::ST_FAIL;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= fdm_pkg::ST_BOOT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Degrade marks are sticky so a healed signal cannot re-enable a device
  // RULE22 restrictions accumulate
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      deg_ff <= 4'h0;
    end else begin
      deg_ff <= deg_ff | deg_set;
    end
  end

  // RULE14 log critical faults
  fdm_err_buf u_err_buf (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .wr_i(crit_any),
    .code_i(crit_code),
    .rd_idx_i(err_rd_idx_i),
    .rd_code_o(err_rd_code_o),
    .count_o(err_count_o)
  );

  // Parameter answers, reads allowed in every state
  always_comb begin
    nxt_rdata = 8'h00;
    for (int i = 0; i < fdm_pkg::N_CAT; i++) begin
      if (idx_hit[i]) begin
        nxt_rdata = allow_val[i];
      end
    end
  end

  // RULE15 reads answered, writes rejected
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      par_ack_ff <= 1'b0;
      par_rej_ff <= 1'b0;
      par_rdata_ff <= 8'h00;
    end else begin
      par_ack_ff <= wr_accept || (par_rd_i && !par_wr_i && (|idx_hit));
      par_rej_ff <= (par_wr_i && !wr_accept) || (par_rd_i && !par_wr_i && !(|idx_hit));
      if (par_rd_i && !par_wr_i) begin
        par_rdata_ff <= nxt_rdata;
      end
    end
  end

  // Function enables
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      primary_en_ff <= 2'h0;
      secondary_en_ff <= 2'h0;
      closed_loop_ff <= 1'b0;
    end else begin
      // RULE3 primary locked off
      // RULE5 both input variants
      primary_en_ff <= primary_en_req_i & {2{run_state && !deg_ff[fdm_pkg::CAT_PRIMARY]}};
      // RULE4 secondary locked off
      secondary_en_ff <= secondary_en_req_i
                         & {2{run_state && !deg_ff[fdm_pkg::CAT_SECONDARY]}};
      // RULE10 closed loop refused
      closed_loop_ff <= closed_loop_req_i && run_state && !deg_ff[fdm_pkg::CAT_WHEEL];
    end
  end

  // Status broadcast divider
  // RULE20 periodic state message
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_cnt_ff <= '0;
      status_tx_ff <= 1'b0;
      status_state_ff <= 3'h0;
    end else if (status_cnt_ff == fdm_pkg::STATUS_CNT_W'(STATUS_PERIOD - 1)) begin
      status_cnt_ff <= '0;
      status_tx_ff <= 1'b1;
      status_state_ff <= state_ff;
    end else begin
      status_cnt_ff <= status_cnt_ff + fdm_pkg::STATUS_CNT_W'(1);
      status_tx_ff <= 1'b0;
    end
  end

  // Outputs
  assign par_ack_o = par_ack_ff;
  assign par_rej_o = par_rej_ff;
  assign par_rdata_o = par_rdata_ff;
  assign op_state_o = state_ff;
  assign status_tx_o = status_tx_ff;
  assign status_state_o = status_state_ff;
  assign critical_o = (state_ff == fdm_pkg::ST_FAIL);
  // RULE13 bridge off in fail-safe
  assign valve_bridge_en_o = run_state;
  assign primary_dev_en_o = primary_en_ff;
  assign secondary_dev_en_o = secondary_en_ff;
  // RULE6 speed sensitivity bypass
  // RULE11 only speed consumers touched
  assign speed_sens_bypass_o = deg_ff[fdm_pkg::CAT_SPEED];
  assign assume_max_speed_o = deg_ff[fdm_pkg::CAT_SPEED];
  // RULE7 speed ramp bypass
  assign speed_ramp_bypass_o = deg_ff[fdm_pkg::CAT_SPEED];
  // RULE8 transition speed ignored
  assign trans_speed_ignore_o = deg_ff[fdm_pkg::CAT_SPEED];
  // RULE9 wheel functions bypassed
  assign soft_stop_bypass_o = deg_ff[fdm_pkg::CAT_WHEEL];
  assign act_sens_bypass_o = deg_ff[fdm_pkg::CAT_WHEEL];

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_fail_latched: assert property ( // RULE21
    state_ff == fdm_pkg::ST_FAIL |=> (state_ff == fdm_pkg::ST_FAIL) [*4])
    else $error("fail-safe state was left");

  a_critical_to_fail: assert property ( // RULE19
    crit_any |=> (state_ff == fdm_pkg::ST_FAIL) && !valve_bridge_en_o)
    else $error("critical fault did not reach fail-safe");

  a_flag_false_fail: assert property ( // RULE2
    (cat_fault_i[fdm_pkg::CAT_SPEED] && !allow_true[fdm_pkg::CAT_SPEED])
    |=> critical_o)
    else $error("fault with false flag did not fail");

  a_reduced_entry: assert property ( // RULE12
    (state_ff == fdm_pkg::ST_OPER) && (|deg_set) && !crit_any
    |=> state_ff == fdm_pkg::ST_RED)
    else $error("allowed fault did not enter reduced state");

  a_bridge_off: assert property ( // RULE13
    state_ff == fdm_pkg::ST_FAIL |-> !valve_bridge_en_o)
    else $error("valve bridge enabled in fail-safe");

  a_write_blocked: assert property ( // RULE15
    par_wr_i && (state_ff == fdm_pkg::ST_FAIL)
    |=> par_rej_o && !par_ack_o && $stable(allow_val[0]))
    else $error("parameter write taken in fail-safe");

  a_primary_locked: assert property ( // RULE3
    deg_ff[fdm_pkg::CAT_PRIMARY] |=> primary_dev_en_o == 2'h0)
    else $error("primary device enabled after its fault");

  a_secondary_locked: assert property ( // RULE4
    deg_ff[fdm_pkg::CAT_SECONDARY] |=> secondary_dev_en_o == 2'h0)
    else $error("secondary device enabled after its fault");

  a_speed_bypass: assert property ( // RULE6
    deg_set[fdm_pkg::CAT_SPEED] |=> speed_sens_bypass_o && speed_ramp_bypass_o
    && trans_speed_ignore_o && assume_max_speed_o && ($past(deg_set[fdm_pkg::CAT_WHEEL])
    || (soft_stop_bypass_o == $past(soft_stop_bypass_o))))
    else $error("speed fault bypass missing");

  a_closed_loop_off: assert property ( // RULE10
    deg_set[fdm_pkg::CAT_WHEEL] |=> ##1 !closed_loop_en_o)
    else $error("closed loop allowed after wheel fault");

  a_fault_logged: assert property ( // RULE14
    crit_any && (err_count_o != fdm_pkg::ERR_CNT_FULL)
    |=> err_count_o == $past(err_count_o) + 4'h1)
    else $error("critical fault not logged");

  assign closed_loop_en_o = closed_loop_ff;

endmodule : fdm_manager
`default_nettype wire

// ==== dv/fdm_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none
module fdm_far_side (
  // Clock
  input wire logic clk_i,
  // Fault events and requests toward the manager
  output logic [3:0] cat_fault_o,
  output logic [4:0] diag_fault_o,
  output logic [1:0] primary_en_req_o,
  output logic [1:0] secondary_en_req_o,
  output logic closed_loop_req_o
);
  initial begin
    cat_fault_o = 4'h0;
    diag_fault_o = 5'h00;
    primary_en_req_o = 2'h0;
    secondary_en_req_o = 2'h0;
    closed_loop_req_o = 1'b0;
  end

  // One-cycle detection pulse; a held level would log every cycle
  task automatic raise_fault(input logic [8:0] src);
    @(posedge clk_i);
    #1;
    cat_fault_o = src[3:0];
    diag_fault_o = src[8:4];
    @(posedge clk_i);
    #1;
    cat_fault_o = 4'h0;
    diag_fault_o = 5'h00;
  endtask : raise_fault

  task automatic set_requests(input logic [1:0] pri, input logic [1:0] sec, input logic cl);
    @(posedge clk_i);
    #1;
    primary_en_req_o = pri;
    secondary_en_req_o = sec;
    closed_loop_req_o = cl;
  endtask : set_requests
endmodule : fdm_far_side
`default_nettype wire

// ==== dv/fdm_manager_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module fdm_manager_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cal_strap = 1'b0;
  logic par_wr = 1'b0;
  logic par_rd = 1'b0;
  logic [15:0] par_idx = 16'h0000;
  logic [7:0] par_wdata = 8'h00;
  logic [2:0] err_rd_idx = 3'h0;
  logic [3:0] cat_fault;
  logic [4:0] diag_fault;
  logic [1:0] pri_req, sec_req;
  logic cl_req, par_ack, par_rej, status_tx, critical, bridge_en, closed_loop_en;
  logic [7:0] par_rdata;
  logic [3:0] err_code, err_count;
  logic [2:0] op_state, status_state;
  logic [1:0] pri_en, sec_en;
  logic sp_sens, sp_ramp, tr_ignore, max_speed, soft_byp, act_byp;
  int err_total = 0;
  int n_compared = 0;

  always #5 clk = ~clk;

  fdm_far_side far (
    .clk_i(clk), .cat_fault_o(cat_fault), .diag_fault_o(diag_fault),
    .primary_en_req_o(pri_req), .secondary_en_req_o(sec_req), .closed_loop_req_o(cl_req)
  );

  // Short status period keeps the run brief
  fdm_manager #(.STATUS_PERIOD(16)) dut (
    .clk_i(clk), .arst_n_i(arst_n), .cal_strap_i(cal_strap),
    .cat_fault_i(cat_fault), .diag_fault_i(diag_fault),
    .primary_en_req_i(pri_req), .secondary_en_req_i(sec_req), .closed_loop_req_i(cl_req),
    .par_wr_i(par_wr), .par_rd_i(par_rd), .par_idx_i(par_idx), .par_wdata_i(par_wdata),
    .par_ack_o(par_ack), .par_rej_o(par_rej), .par_rdata_o(par_rdata),
    .err_rd_idx_i(err_rd_idx), .err_rd_code_o(err_code), .err_count_o(err_count),
    .op_state_o(op_state), .status_tx_o(status_tx), .status_state_o(status_state),
    .critical_o(critical), .valve_bridge_en_o(bridge_en),
    .primary_dev_en_o(pri_en), .secondary_dev_en_o(sec_en),
    .speed_sens_bypass_o(sp_sens), .speed_ramp_bypass_o(sp_ramp),
    .trans_speed_ignore_o(tr_ignore), .assume_max_speed_o(max_speed),
    .soft_stop_bypass_o(soft_byp), .act_sens_bypass_o(act_byp),
    .closed_loop_en_o(closed_loop_en)
  );

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic check_resp(input logic ack, input logic rej, input logic ok);
    n_compared++;
    if ({ack, rej} !== (ok ? 2'b10 : 2'b01)) begin
      err_total++;
      $display("CHECK FAILED at %0t: access answer %b%b, accept expected %b", $time, ack, rej, ok);
    end
  endtask : check_resp

  // Request held through the taking edge, answer read right after it
  task automatic par_access(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                            input logic ok, input logic [7:0] exp_rd);
    @(posedge clk);
    #1;
    par_wr = wr;
    par_rd = !wr;
    par_idx = idx;
    par_wdata = wd;
    @(posedge clk);
    #1;
    par_wr = 1'b0;
    par_rd = 1'b0;
    check_resp(par_ack, par_rej, ok);
    if (!wr) begin
      check_val(par_rdata, exp_rd, "read data");
    end
  endtask : par_access

  task automatic do_reset(input logic strap);
    arst_n = 1'b0;
    cal_strap = strap;
    repeat (5) @(posedge clk);
    #1;
    arst_n = 1'b1;
    @(posedge clk);
    #1;
  endtask : do_reset

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    do_reset(1'b0);
    check_val({5'h0, op_state}, {5'h0, fdm_pkg::ST_OPER}, "state");
    check_val({7'h0, bridge_en}, 8'h01, "bridge");
    for (int i = 0; i < 4; i++) begin
      par_access(1'b0, 16'hfa0b + 16'(i), 8'h00, 1'b1, fdm_pkg::ALLOW_RESET);
    end
    par_access(1'b0, 16'hfa0f, 8'h00, 1'b0, 8'h00);
    par_access(1'b1, fdm_pkg::IDX_SPEED_ALLOW, 8'h55, 1'b0, 8'h00);
    $display("test reset_values done");

    // Every source with its flag false ends in fail-safe
    for (int n = 0; n < 9; n++) begin
      do_reset(1'b0);
      far.raise_fault(9'(1 << n));
      check_val({5'h0, op_state}, {5'h0, fdm_pkg::ST_FAIL}, "state");
      check_val({6'h0, critical, bridge_en}, 8'h02, "critical");
      @(posedge clk);
      #1;
      check_val({4'h0, err_count}, 8'h01, "log count");
      check_val({4'h0, err_code}, (n < 4) ? {4'h0, fdm_pkg::CODE_CAT_BASE + 4'(n)} :
                {4'h0, fdm_pkg::CODE_DIAG_BASE + 4'(n - 4)}, "log code");
      err_rd_idx = 3'h1;
      @(posedge clk);
      #1;
      check_val({4'h0, err_code}, 8'h00, "empty entry");
      err_rd_idx = 3'h0;
      par_access(1'b1, fdm_pkg::IDX_SPEED_ALLOW, fdm_pkg::ALLOW_TRUE, 1'b0, 8'h00);
      par_access(1'b0, fdm_pkg::IDX_SPEED_ALLOW, 8'h00, 1'b1, fdm_pkg::ALLOW_FALSE);
      check_val({5'h0, op_state}, {5'h0, fdm_pkg::ST_FAIL}, "latched");
    end
    $display("test fail_safe done");

    do_reset(1'b0);
    check_val({5'h0, op_state}, {5'h0, fdm_pkg::ST_OPER}, "after power cycle");
    for (int i = 0; i < 4; i++) begin
      par_access(1'b1, 16'hfa0b + 16'(i), fdm_pkg::ALLOW_TRUE, 1'b1, 8'h00);
      par_access(1'b0, 16'hfa0b + 16'(i), 8'h00, 1'b1, fdm_pkg::ALLOW_TRUE);
    end
    far.set_requests(2'h3, 2'h3, 1'b1);
    settle();
    check_val({3'h0, pri_en, sec_en, closed_loop_en}, 8'h1f, "enables");
    far.raise_fault(9'h004);
    check_val({5'h0, op_state}, {5'h0, fdm_pkg::ST_RED}, "state");
    check_val({4'h0, sp_sens, sp_ramp, tr_ignore, max_speed}, 8'h0f, "speed");
    check_val({6'h0, soft_byp, act_byp}, 8'h00, "wheel marks");
    settle();
    check_val({3'h0, pri_en, sec_en, closed_loop_en}, 8'h1f, "enables");
    far.raise_fault(9'h008);
    settle();
    check_val({6'h0, soft_byp, act_byp}, 8'h03, "wheel marks");
    check_val({7'h0, closed_loop_en}, 8'h00, "closed loop");
    check_val({4'h0, sp_sens, sp_ramp, tr_ignore, max_speed}, 8'h0f, "speed");
    far.raise_fault(9'h001);
    settle();
    check_val({4'h0, pri_en, sec_en}, 8'h03, "primary off");
    far.raise_fault(9'h002);
    settle();
    check_val({4'h0, pri_en, sec_en}, 8'h00, "secondary off");
    check_val({5'h0, op_state}, {5'h0, fdm_pkg::ST_RED}, "state");
    check_val({4'h0, err_count}, 8'h00, "no log");
    par_access(1'b1, fdm_pkg::IDX_WHEEL_ALLOW, fdm_pkg::ALLOW_FALSE, 1'b1, 8'h00);
    far.set_requests(2'h0, 2'h0, 1'b0);
    far.set_requests(2'h3, 2'h3, 1'b1);
    settle();
    check_val({3'h0, pri_en, sec_en, closed_loop_en}, 8'h00, "re-enable");
    $display("test reduced done");

    for (int k = 0; k < 40 && status_tx !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    check_val({7'h0, status_tx}, 8'h01, "status pulse");
    check_val({5'h0, status_state}, {5'h0, fdm_pkg::ST_RED}, "status state");
    $display("test status done");

    do_reset(1'b1);
    check_val({5'h0, op_state}, {5'h0, fdm_pkg::ST_CAL}, "state");
    par_access(1'b1, fdm_pkg::IDX_PRIMARY_ALLOW, fdm_pkg::ALLOW_TRUE, 1'b1, 8'h00);
    far.raise_fault(9'h100);
    check_val({5'h0, op_state}, {5'h0, fdm_pkg::ST_FAIL}, "cal to fail");
    $display("test calibration done");
    stop_test();
  end
endmodule : fdm_manager_bench
`default_nettype wire
